// ===== logic/dcc_map.svh
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH
// Register byte addresses on the AXI4-Lite slave.
`define DCC_CTRL1_ADDR   8'h00
`define DCC_VALUE1_ADDR  8'h04
`define DCC_CTRL2_ADDR   8'h08
`define DCC_VALUE2_ADDR  8'h0C
`define DCC_STATUS_ADDR  8'h10
`define DCC_TIMER_ADDR   8'h14
// Field positions.
`define DCC_MODE_MSB     3
`define DCC_DUTY_LSB     4
`define DCC_DUTY_MSB     5
`define DCC_STAT_FLAG1   0
`define DCC_STAT_FLAG2   1
`define DCC_STAT_SYNC    2
`define DCC_STAT_PINSEL  3
`define DCC_STAT_OUT1    4
`define DCC_STAT_OUT2    5
// Mode codes of the four-bit channel mode field.
`define DCC_M_OFF        4'h0
`define DCC_M_TOGGLE     4'h2
`define DCC_M_CAP_FALL   4'h4
`define DCC_M_CAP_RISE   4'h5
`define DCC_M_CAP_RISE4  4'h6
`define DCC_M_CAP_RISE16 4'h7
`define DCC_M_SET_HIGH   4'h8
`define DCC_M_SET_LOW    4'h9
`define DCC_M_SOFT_IRQ   4'hA
`define DCC_M_SPECIAL    4'hB
// Prescaler terminal counts for every 4th and every 16th edge.
`define DCC_PS4_LAST     4'h3
`define DCC_PS16_LAST    4'hF
// Reset values and AXI responses.
`define DCC_RST_BYTE     8'h00
`define DCC_RST_WORD     16'h0000
`define DCC_RESP_OKAY    2'b00
`define DCC_RESP_SLVERR  2'b10
`endif

// ===== logic/dcc_pkg.sv
package dcc_pkg;
   // Decoded operating class of one channel.
   typedef enum logic [3:0] {
      DCC_OFF     = 4'b0001,
      DCC_CAPTURE = 4'b0010,
      DCC_COMPARE = 4'b0100,
      DCC_PWM     = 4'b1000
   } dcc_class_t;
   // Per-channel software state: control byte and the value register pair.
   typedef struct packed {
      logic [7:0]  control;
      logic [15:0] value;
   } dcc_chan_t;
   // Channel event outputs to the timers and converter.
   typedef struct packed {
      logic match;
      logic timer1_reset;
      logic start_conv;
   } dcc_evt_t;
endpackage : dcc_pkg

// ===== logic/dcc_unit.sv
// Operation
// [RULE1] Capture and compare use timer one; PWM uses timer two.
// [RULE2] Both channels run at once, sharing their class's timer.
// [RULE3] Capture works only while timer one is synchronous.
// [RULE4] Strap high routes channel two to C1, low to B3.
// [RULE5] Channel two special event clears timer one, starts conversion.
// [RULE6] Channel one special event clears timer one.
// [RULE7] Either may clear timer one; only channel two converts.
// [RULE8] PWM channels share the timer-two period and update.
// [RULE9] A capture loads all sixteen timer-one bits.
// [RULE10] Capture on falling, rising, fourth or sixteenth rising edge.
// [RULE11] A capture sets the flag; only software clears it.
// [RULE12] A newer capture overwrites an unread value.
// [RULE13] A port write toggling the routed pin can capture.
// [RULE14] Software masks and clears the flag on mode changes.
// [RULE15] Prescaler clears when off, outside capture, or in reset.
// [RULE16] Switching prescaler settings keeps the count.
// [RULE17] A 16-bit match sets, clears, toggles or keeps the pin.
// [RULE18] Zero control on channel two forces its latch low.
// [RULE19] Software keeps timer one synchronous for compare.
// [RULE20] Mode 1010 only sets the flag.
// [RULE21] Software sets pin direction per mode.
// [RULE22] Simultaneous captures sample one timer value.
// [RULE23] Codes 0100 to 0111 capture; 0000 resets the channel.
// [RULE24] Codes 0010, 1000, 1001, 1011 compare; 11xx is PWM.
// [RULE25] Special event clears the serving timer.
// [RULE26] One match per timer step, one flag set and action.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "dcc_map.svh"
module dcc_unit (
   input  wire logic        aclk,              // System clock, 250 MHz.
   input  wire logic        aresetn,           // Synchronous reset, active low.
   input  wire logic [7:0]  s_axi_awaddr,      // Write address.
   input  wire logic        s_axi_awvalid,     // Write address valid.
   output logic             s_axi_awready,     // Write address ready.
   input  wire logic [31:0] s_axi_wdata,       // Write data.
   input  wire logic [3:0]  s_axi_wstrb,       // Write byte strobes.
   input  wire logic        s_axi_wvalid,      // Write data valid.
   output logic             s_axi_wready,      // Write data ready.
   output logic [1:0]       s_axi_bresp,       // Write response.
   output logic             s_axi_bvalid,      // Write response valid.
   input  wire logic        s_axi_bready,      // Write response ready.
   input  wire logic [7:0]  s_axi_araddr,      // Read address.
   input  wire logic        s_axi_arvalid,     // Read address valid.
   output logic             s_axi_arready,     // Read address ready.
   output logic [31:0]      s_axi_rdata,       // Read data.
   output logic [1:0]       s_axi_rresp,       // Read response.
   output logic             s_axi_rvalid,      // Read data valid.
   input  wire logic        s_axi_rready,      // Read data ready.
   input  wire logic [15:0] timer_one_count,   // Free-running capture/compare time base.
   input  wire logic        timer_one_tick,    // One-cycle pulse when timer one increments.
   input  wire logic        timer_one_sync,    // High while timer one is clocked synchronously.
   input  wire logic        timer_two_match,   // One-cycle pulse on the timer-two period match.
   input  wire logic        conv_enabled,      // Converter enabled and able to start.
   input  wire logic        second_channel_pin_select, // Configuration strap for channel two.
   input  wire logic        first_pin_in,      // Channel one pin level.
   input  wire logic        port_c_pin_one_in, // Port C pin one level.
   input  wire logic        port_b_pin_three_in, // Port B pin three level.
   output logic             first_out_q,       // Channel one compare output latch.
   output logic             port_c_pin_one_out_q,   // Channel two latch when routed to C1.
   output logic             port_b_pin_three_out_q, // Channel two latch when routed to B3.
   output logic             first_drive_q,     // Channel one owns its pin (compare action).
   output logic             second_drive_q,    // Channel two owns its routed pin.
   output logic             timer_one_reset_q, // Pulse: clear timer one.
   output logic             timer_two_reset_q, // Clear timer two; always low, PWM has no trigger code.
   output logic             conv_start_q,      // Pulse: start a conversion.
   output logic             pwm_update_q,      // Pulse: shared PWM duty update event.
   output logic [1:0]       request_flag_q     // Channel request flags, level.
);

   // Classify a mode field; used for both channels.
   function automatic dcc_pkg::dcc_class_t mode_class(input logic [3:0] m);
      dcc_pkg::dcc_class_t c;
      c = dcc_pkg::DCC_OFF;
      if (m[3] && m[2]) begin
         c = dcc_pkg::DCC_PWM; // RULE24
      end else if (!m[3] && m[2]) begin
         c = dcc_pkg::DCC_CAPTURE; // RULE23
      end else if (m == `DCC_M_TOGGLE || m[3]) begin
         c = dcc_pkg::DCC_COMPARE; // RULE24
      end
      return c;
   endfunction : mode_class

   // Decide whether a pin edge is a qualifying capture event.
   function automatic logic cap_edge(input logic [3:0] m, input logic prev, input logic now);
      logic r;
      r = 1'b0;
      if (m == `DCC_M_CAP_FALL) begin
         r = prev && !now; // RULE10
      end else begin
         r = !prev && now;
      end
      return r;
   endfunction : cap_edge

   dcc_pkg::dcc_chan_t ch_q [2];
   dcc_pkg::dcc_chan_t ch_d [2];
   logic [1:0]  flag_q, flag_d;
   logic [1:0]  out_q, out_d;
   logic [1:0]  pin_prev_q, pin_prev_d;
   logic [3:0]  ps_q [2];
   logic [3:0]  ps_d [2];
   logic [1:0]  hit_q, hit_d;

   logic        pinsel_q, pinsel_d;
   logic        strap_done_q, strap_done_d;

   dcc_pkg::dcc_evt_t evt [2];
   logic [1:0]  pin_now;
   logic [1:0]  cap_event;
   logic [1:0]  wr_ctrl;
   logic [1:0]  wr_val;
   logic [7:0]  wr_byte;
   logic [15:0] wr_word;

   logic        aw_q, aw_d, w_q, w_d;
   logic        bv_q, bv_d, rv_q, rv_d, bok_q, bok_d;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d;
   logic [31:0] rd_q, rd_d;
   logic [3:0]  ws_q, ws_d;
   logic [1:0]  rr_q, rr_d;

   logic        t1r_d, t2r_d;
   logic        conv_d, upd_d;

   // Channel two input routing; the strap is caught once after reset release.
   always_comb begin
      pin_now[0] = first_pin_in;
      pin_now[1] = pinsel_q ? port_c_pin_one_in : port_b_pin_three_in; // RULE4 RULE13
      pinsel_d = strap_done_q ? pinsel_q : second_channel_pin_select;
      strap_done_d = 1'b1;
   end

   // AXI4-Lite slave: address and data may come in either order; one response follows both.
   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      ws_d = ws_q;
      bv_d = bv_q;
      bok_d = bok_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      wr_ctrl = 2'b00;
      wr_val = 2'b00;
      wr_byte = wd_q[7:0];
      wr_word = wd_q[15:0];
      if (s_axi_awvalid && !aw_q && !bv_q) begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q && !bv_q) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (aw_q && w_q) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         bok_d = 1'b1;
         unique case (awa_q)
            `DCC_CTRL1_ADDR: wr_ctrl[0] = ws_q[0];
            `DCC_CTRL2_ADDR: wr_ctrl[1] = ws_q[0];
            `DCC_VALUE1_ADDR: wr_val[0] = |ws_q[1:0];
            `DCC_VALUE2_ADDR: wr_val[1] = |ws_q[1:0];
            `DCC_STATUS_ADDR: ;
            default: bok_d = 1'b0;
         endcase
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      // Reads run beside writes.
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = `DCC_RESP_OKAY;
         rd_d = 32'h0000_0000;
         unique case (s_axi_araddr)
            `DCC_CTRL1_ADDR: rd_d[7:0] = ch_q[0].control;
            `DCC_CTRL2_ADDR: rd_d[7:0] = ch_q[1].control;
            `DCC_VALUE1_ADDR: rd_d[15:0] = ch_q[0].value;
            `DCC_VALUE2_ADDR: rd_d[15:0] = ch_q[1].value;
            `DCC_TIMER_ADDR: rd_d[15:0] = timer_one_count;
            `DCC_STATUS_ADDR: rd_d[5:0] = {out_q, pinsel_q, timer_one_sync, flag_q};
            default: rr_d = `DCC_RESP_SLVERR;
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   // Per-channel capture, compare, prescaler and flag logic.
   always_comb begin
      t1r_d = 1'b0;
      t2r_d = 1'b0;
      conv_d = 1'b0;
      upd_d = 1'b0;
      flag_d = flag_q;
      out_d = out_q;
      hit_d = hit_q;
      pin_prev_d = pin_now;
      for (int i = 0; i < 2; i++) begin
         dcc_pkg::dcc_class_t cls;
         logic [3:0] m;
         logic [3:0] last;
         logic       edge_seen;
         ch_d[i] = ch_q[i];
         ps_d[i] = ps_q[i];
         m = ch_q[i].control[`DCC_MODE_MSB:0];
         cls = mode_class(m);
         last = (m == `DCC_M_CAP_RISE16) ? `DCC_PS16_LAST : `DCC_PS4_LAST;
         // Capture while timer one is unsynchronised is undefined, so it is held off.
         edge_seen = cap_edge(m, pin_prev_q[i], pin_now[i]) && timer_one_sync; // RULE3
         cap_event[i] = 1'b0;
         evt[i] = '0;
         if (cls == dcc_pkg::DCC_CAPTURE && edge_seen) begin
            if (m == `DCC_M_CAP_RISE4 || m == `DCC_M_CAP_RISE16) begin
               cap_event[i] = (ps_q[i] == last);
               ps_d[i] = cap_event[i] ? 4'h0 : ps_q[i] + 4'h1; // RULE16
            end else begin
               cap_event[i] = 1'b1;
            end
         end
         // Leaving capture drops a partial count.
         if (cls != dcc_pkg::DCC_CAPTURE) begin
            ps_d[i] = 4'h0; // RULE15
         end
         if (cap_event[i]) begin
            ch_d[i].value = timer_one_count; // RULE9 RULE12 RULE22
         end
         // Match evaluated once per increment; hit_q blocks repeats while the count stays.
         evt[i].match = cls == dcc_pkg::DCC_COMPARE && timer_one_sync &&
                        ch_q[i].value == timer_one_count && !hit_q[i]; // RULE17 RULE26
         // A match in the tick cycle still blocks repeats until the next step.
         if (evt[i].match) begin
            hit_d[i] = 1'b1;
         end else if (timer_one_tick) begin
            hit_d[i] = 1'b0;
         end
         if (evt[i].match) begin
            unique case (m)
               `DCC_M_TOGGLE: out_d[i] = !out_q[i];
               `DCC_M_SET_HIGH: out_d[i] = 1'b1;
               `DCC_M_SET_LOW: out_d[i] = 1'b0;
               `DCC_M_SPECIAL: evt[i].timer1_reset = 1'b1; // RULE25 RULE5 RULE6 RULE7
               default: ; // RULE20
            endcase
         end
         // Only channel two may start the converter.
         evt[i].start_conv = evt[i].timer1_reset && i == 1 && conv_enabled; // RULE7
         // Software write of the control byte; zero resets the channel.
         if (wr_ctrl[i]) begin
            ch_d[i].control = wr_byte;
            if (wr_byte[`DCC_MODE_MSB:0] == `DCC_M_OFF) begin
               out_d[i] = 1'b0; // RULE18 RULE23
               ps_d[i] = 4'h0; // RULE15
            end else if (wr_byte[`DCC_MODE_MSB:0] == `DCC_M_SET_HIGH) begin
               out_d[i] = 1'b0;
            end else if (wr_byte[`DCC_MODE_MSB:0] == `DCC_M_SET_LOW) begin
               out_d[i] = 1'b1;
            end
         end
         if (wr_val[i]) begin
            ch_d[i].value = wr_word;
         end
         // Status writes of one clear flags, but a same-cycle event wins.
         if (wr_ctrl == 2'b00 && aw_q && w_q && awa_q == `DCC_STATUS_ADDR && ws_q[0] &&
             wd_q[i]) begin
            flag_d[i] = 1'b0;
         end
         if (cap_event[i] || evt[i].match) begin
            flag_d[i] = 1'b1; // RULE11
         end
         t1r_d = t1r_d | evt[i].timer1_reset;
         conv_d = conv_d | evt[i].start_conv;
         // Both PWM channels follow the single timer-two match.
         if (cls == dcc_pkg::DCC_PWM && timer_two_match) begin
            upd_d = 1'b1; // RULE1 RULE2 RULE8
         end
      end
      // Special event in PWM class would target timer two, but PWM has no trigger code.
      t2r_d = 1'b0;
   end

   // Registers: store values computed above, and decode pin drive enables and the C1/B3 latch routing.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 2; i++) begin
            ch_q[i] <= '0;
            ps_q[i] <= 4'h0;
         end
         flag_q <= 2'b00;
         out_q <= 2'b00;
         hit_q <= 2'b00;
         pin_prev_q <= 2'b00;
         pinsel_q <= 1'b1;
         strap_done_q <= 1'b0;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         bv_q <= 1'b0;
         bok_q <= 1'b0;
         rv_q <= 1'b0;
         awa_q <= `DCC_RST_BYTE;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         rd_q <= 32'h0000_0000;
         rr_q <= `DCC_RESP_OKAY;
         first_out_q <= 1'b0;
         port_c_pin_one_out_q <= 1'b0;
         port_b_pin_three_out_q <= 1'b0;
         first_drive_q <= 1'b0;
         second_drive_q <= 1'b0;
         timer_one_reset_q <= 1'b0;
         timer_two_reset_q <= 1'b0;
         conv_start_q <= 1'b0;
         pwm_update_q <= 1'b0;
         request_flag_q <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            ch_q[i] <= ch_d[i];
            ps_q[i] <= ps_d[i];
         end
         flag_q <= flag_d;
         out_q <= out_d;
         hit_q <= hit_d;
         pin_prev_q <= pin_prev_d;
         pinsel_q <= pinsel_d;
         strap_done_q <= strap_done_d;
         aw_q <= aw_d;
         w_q <= w_d;
         bv_q <= bv_d;
         bok_q <= bok_d;
         rv_q <= rv_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         first_out_q <= out_d[0];
         port_c_pin_one_out_q <= pinsel_q ? out_d[1] : 1'b0; // RULE4
         port_b_pin_three_out_q <= pinsel_q ? 1'b0 : out_d[1];
         first_drive_q <= mode_class(ch_d[0].control[`DCC_MODE_MSB:0]) == dcc_pkg::DCC_COMPARE
                          && ch_d[0].control[`DCC_MODE_MSB:0] != `DCC_M_SOFT_IRQ;
         second_drive_q <= mode_class(ch_d[1].control[`DCC_MODE_MSB:0]) == dcc_pkg::DCC_COMPARE
                           && ch_d[1].control[`DCC_MODE_MSB:0] != `DCC_M_SOFT_IRQ; // RULE20
         timer_one_reset_q <= t1r_d;
         timer_two_reset_q <= t2r_d;
         conv_start_q <= conv_d;
         pwm_update_q <= upd_d;
         request_flag_q <= flag_d;
      end
   end

   // Bus handshakes come from registered state.
   always_comb begin
      s_axi_awready = !aw_q && !bv_q;
      s_axi_wready = !w_q && !bv_q;
      s_axi_bvalid = bv_q;
      s_axi_bresp = bok_q ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
      s_axi_arready = !rv_q;
      s_axi_rvalid = rv_q;
      s_axi_rdata = rd_q;
      s_axi_rresp = rr_q;
   end

endmodule : dcc_unit

// ===== tb/dcc_port_model.sv
`timescale 1ns/1ns
// Port pins and a synchronous timer one around the unit.
module dcc_port_model (
   input wire logic         aclk,                 // Clock.
   input wire logic         run,                  // Count one per cycle.
   input wire logic         load,                 // Load the count.
   input wire logic [15:0]  lval,                 // Load value.
   input wire logic         lvl1,                 // Channel one input level.
   input wire logic         lvl2,                 // Channel two input level.
   input wire logic         timer_one_reset_q,    // Timer clear.
   input wire logic         conv_start_q,         // Conversion start.
   input wire logic         first_drive_q,        // Channel one owns pin.
   input wire logic         first_out_q,          // Channel one latch.
   input wire logic         second_drive_q,       // Channel two owns pin.
   input wire logic         port_c_pin_one_out_q, // C1 latch.
   output logic [15:0]      timer_one_count,      // Timer value.
   output logic             timer_one_tick,       // Step pulse.
   output wire logic        first_pin_in,         // Channel one pin.
   output wire logic        port_c_pin_one_in,    // C1 pin.
   output wire logic        port_b_pin_three_in,  // B3 pin, unrouted.
   output int               resets,               // Timer clears seen.
   output int               convs                 // Conversions seen.
);
   initial begin
      timer_one_count = 16'h0000;
      timer_one_tick = 1'b0;
      resets = 0;
      convs = 0;
   end
   // A clear wins over load and count, as the serving timer must restart.
   always @(posedge aclk) begin
      timer_one_tick <= 1'b0;
      if (timer_one_reset_q) begin
         timer_one_count <= 16'h0000;
         resets <= resets + 1;
      end else if (load) timer_one_count <= lval;
      else if (run) begin
         timer_one_count <= timer_one_count + 16'h0001;
         timer_one_tick <= 1'b1;
      end
      if (conv_start_q) convs <= convs + 1;
   end
   // Pins are outputs while compare owns them, inputs otherwise; B3 wanders.
   assign first_pin_in = first_drive_q ? first_out_q : lvl1;
   assign port_c_pin_one_in = second_drive_q ? port_c_pin_one_out_q : lvl2;
   assign port_b_pin_three_in = timer_one_count[0];
endmodule : dcc_port_model

// ===== tb/dcc_unit_sva.sv
`timescale 1ns/1ns
// Checks event, latch and reset behaviour seen at the unit's pins.
module dcc_unit_sva (
   input wire logic       aclk,                      // Clock.
   input wire logic       aresetn,                   // Reset, active low.
   input wire logic       s_axi_wvalid,              // Write data offered.
   input wire logic       s_axi_bvalid,              // Write answered.
   input wire logic       first_pin_in,              // Channel one pin.
   input wire logic       timer_one_tick,            // Timer one step.
   input wire logic       timer_two_match,           // Timer two match.
   input wire logic       conv_enabled,              // Converter ready.
   input wire logic       second_channel_pin_select, // Routing strap.
   input wire logic       port_b_pin_three_out_q,    // B3 latch.
   input wire logic       first_out_q,               // Channel one latch.
   input wire logic       timer_one_reset_q,         // Timer one clear.
   input wire logic       timer_two_reset_q,         // Timer two clear.
   input wire logic       conv_start_q,              // Conversion start.
   input wire logic       pwm_update_q,              // PWM update.
   input wire logic [1:0] request_flag_q             // Request flags.
);
   logic       pin_q;
   logic [2:0] act_q;
   logic [2:0] act_d;
   // Cycles since the last possible cause, saturating.
   always_comb begin
      act_d = (act_q == 3'h7) ? act_q : act_q + 3'h1;
      if (first_pin_in != pin_q || timer_one_tick || s_axi_wvalid) act_d = 3'h0;
   end
   // Registers the history; reset counts as a cause.
   always_ff @(posedge aclk) begin
      pin_q <= first_pin_in;
      act_q <= aresetn ? act_d : 3'h0;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_rst_clear: assert property (disable iff (1'b0)
      !aresetn |=> request_flag_q == 2'b00 && !first_out_q && !conv_start_q)
      else $error("Outputs not cleared by reset.");
   a_flag_cause: assert property ($rose(request_flag_q[0]) |-> act_q <= 3'h3)
      else $error("Flag rose without pin edge or tick.");
   a_latch_cause: assert property ($changed(first_out_q) |-> act_q <= 3'h3)
      else $error("Latch moved without match or write.");
   a_flag_sticky: assert property ($fell(request_flag_q[0]) |-> s_axi_bvalid)
      else $error("Flag cleared without a write.");
   a_reset_pulse: assert property (timer_one_reset_q |=> !timer_one_reset_q)
      else $error("Timer clear longer than one cycle.");
   a_reset_cause: assert property (timer_one_reset_q |-> act_q <= 3'h3)
      else $error("Timer clear without a tick.");
   a_conv_pair: assert property (conv_start_q |-> timer_one_reset_q && $past(conv_enabled))
      else $error("Conversion start without timer clear.");
   a_timer_two_count_idle: assert property (timer_two_reset_q == 1'b0)
      else $error("Timer two cleared by compare.");
   a_pwm_match: assert property (pwm_update_q |-> $past(timer_two_match))
      else $error("PWM update without timer two match.");
   a_pin_route: assert property (second_channel_pin_select |-> !port_b_pin_three_out_q)
      else $error("B3 latch driven while routed to C1.");
endmodule : dcc_unit_sva
bind dcc_unit dcc_unit_sva dcc_unit_sva_inst (.*);

// ===== tb/dcc_unit_test.sv
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module dcc_unit_test;
   logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, request_flag_q;
   logic [15:0] timer_one_count, lval = 16'h0;
   logic        timer_one_tick, timer_two_match = 1'b0, conv_enabled = 1'b0;
   logic        timer_one_sync = 1'b1;
   logic        second_channel_pin_select = 1'b1, first_pin_in, port_c_pin_one_in;
   logic        port_b_pin_three_in, first_out_q, port_c_pin_one_out_q, port_b_pin_three_out_q;
   logic        first_drive_q, second_drive_q, timer_one_reset_q, timer_two_reset_q;
   logic        conv_start_q, pwm_update_q, run = 1'b0, load = 1'b0, lvl1 = 1'b0, lvl2 = 1'b0;
   logic [33:0] expq[$], ev;
   logic [3:0]  mt[5] = '{4'h8, 4'h2, 4'hA, 4'h9, 4'hB};
   int          miscompares = 0, num_checks = 0, resets, convs, seed = 32'h779e;
   dcc_unit dcc_unit_inst (.*);
   dcc_port_model dcc_port_model_inst (.*);
   // Free-running 4 ns clock.
   initial forever #2 aclk = ~aclk;
   // Every read answer is matched against the oldest note.
   always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) begin
      ev = expq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, ev)
   end
   function automatic logic [33:0] st(input logic [1:0] f, input logic o1, input logic o2);
      st = {28'h0, o2, o1, 2'b11, f};
   endfunction : st
   task automatic wrap_up();
      if (expq.size() != 0) miscompares++;
      $display("Checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic tmo(input int n);
      if (n >= 200) begin
         miscompares++;
         $display("CHECK FAILED t=%0t wait expired", $time);
         wrap_up();
      end
   endtask : tmo
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int   n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 200);
      s_axi_bready <= 1'b0;
      tmo(n);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      int n;
      n = 0;
      expq.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 200);
      s_axi_rready <= 1'b0;
      tmo(n);
   endtask : rd
   task automatic settle(input logic [15:0] t);
      @(posedge aclk);
      load <= 1'b1;
      lval <= t;
      @(posedge aclk);
      load <= 1'b0;
   endtask : settle
   // Mode written only from zero so the prescaler starts clean; flags cleared after.
   task automatic cap(input logic [3:0] m);
      int          k;
      logic        s;
      logic [15:0] t;
      k = (m == 4'h6) ? 4 : (m == 4'h7) ? 16 : 1;
      s = (m == 4'h4);
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h0);
      lvl1 <= s;
      lvl2 <= s;
      wr(8'h00, {28'h0, m});
      wr(8'h08, {28'h0, m});
      wr(8'h10, 32'h3);
      for (int r = 0; r < 2; r++) begin
         t = 16'($random(seed));
         settle(t);
         for (int i = 0; i < k; i++) begin
            if (i == k - 1) `CHK(request_flag_q, (r ? 2'b11 : 2'b00))
            repeat (2) @(posedge aclk);
            lvl1 <= !s;
            lvl2 <= !s;
            repeat (2) @(posedge aclk);
            lvl1 <= s;
            lvl2 <= s;
         end
         repeat (4) @(posedge aclk);
         rd(8'h04, {18'h0, t});
         rd(8'h0C, {18'h0, t});
      end
      rd(8'h10, st(2'b11, 1'b0, 1'b0));
      $display("TEST capture mode %h done", m);
   endtask : cap
   // Both latches start low, but the chosen one starts high in set-low mode; the chosen channel then meets one match.
   task automatic cmp(input logic ch, input logic [3:0] m);
      int          n;
      logic        o;
      logic [15:0] v;
      n = 0;
      v = 16'($random(seed));
      o = (m == 4'h8 || m == 4'h2);
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h0);
      wr({4'h0, ch, 3'h4}, {16'h0, v});
      settle(v - 16'h0004);
      wr({4'h0, ch, 3'h0}, {28'h0, m});
      wr(8'h10, 32'h3);
      rd(8'h10, st(2'b00, !ch && m == 4'h9, ch && m == 4'h9));
      run <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (request_flag_q[ch] !== 1'b1 && n < 200);
      run <= 1'b0;
      tmo(n);
      repeat (3) @(posedge aclk);
      rd(8'h10, st({ch, !ch}, !ch && o, ch && o));
      $display("TEST compare channel %0d mode %h done", ch, m);
   endtask : cmp
   // Main sequence.
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 7; a++) rd(8'(a * 4), (a == 4) ? st(2'b00, 1'b0, 1'b0) :
         (a == 6) ? {2'b10, 32'h0} : 34'h0);
      $display("TEST reset values done");
      for (int m = 4; m < 8; m++) cap(4'(m));
      conv_enabled <= 1'b1;
      for (int i = 0; i < 10; i++) cmp(1'(i % 2), mt[i / 2]);
      `CHK(resets, 2)
      `CHK(convs, 1)
      wr(8'h00, 32'hC);
      wr(8'h08, 32'hC);
      timer_two_match <= 1'b1;
      @(posedge aclk);
      timer_two_match <= 1'b0;
      @(posedge aclk);
      `CHK(pwm_update_q, 1'b1)
      $display("TEST shared period done");
      wrap_up();
   end
endmodule : dcc_unit_test
